//--- rtl/exc_seq_pkg.sv
//==============================================================================
//==============================================================================
package exc_seq_pkg;

  //============================================================================
  // Widths
  localparam int TAG_W = 6;
  localparam int PC_W = 32;
  localparam int SYNC_N = 10;
  localparam int SYNC_IW = 4;
  localparam int ASYNC_N = 5;
  localparam int ASYNC_IW = 3;
  localparam int CODE_W = 5;
  localparam int RA_W = 6;
  localparam int MS_W = 2;
  localparam int AEN_W = 3;
  localparam int IS_W = 3;

  //============================================================================
  // Synchronous condition bits, lowest index wins within one instruction
  localparam int SY_ISI = 0;
  localparam int SY_DSI = 1;
  localparam int SY_ALIGN = 2;
  localparam int SY_PROGRAM = 3;
  localparam int SY_FP_UNAVAIL = 4;
  localparam int SY_SYSCALL = 5;
  localparam int SY_TRACE = 6;
  localparam int SY_ITLB_MISS = 7;
  localparam int SY_DLD_MISS = 8;
  localparam int SY_DST_MISS = 9;
  localparam logic [SYNC_N-1:0] TLB_MISS_MASK = 10'h380;

  // Asynchronous precise sources
  localparam int AS_EXT = 0;
  localparam int AS_SMI = 1;
  localparam int AS_DEC = 2;
  localparam int AS_PERF = 3;
  localparam int AS_THERM = 4;

  // Cause codes reported in the cause register
  localparam logic [CODE_W-1:0] CODE_SYSRST = 5'h00;
  localparam logic [CODE_W-1:0] CODE_MCHECK = 5'h01;
  localparam logic [CODE_W-1:0] CODE_SYNC_BASE = 5'h02;
  localparam logic [CODE_W-1:0] CODE_ASYNC_BASE = 5'h0C;

  //============================================================================
  // Register offsets (byte addresses)
  localparam logic [RA_W-1:0] OFS_MSTATE = 6'h00;
  localparam logic [RA_W-1:0] OFS_HWCFG = 6'h04;
  localparam logic [RA_W-1:0] OFS_AEN = 6'h08;
  localparam logic [RA_W-1:0] OFS_SRA = 6'h0C;
  localparam logic [RA_W-1:0] OFS_SRS = 6'h10;
  localparam logic [RA_W-1:0] OFS_DFC = 6'h14;
  localparam logic [RA_W-1:0] OFS_CAUSE = 6'h18;
  localparam logic [RA_W-1:0] OFS_ISTAT = 6'h1C;
  localparam logic [RA_W-1:0] OFS_IMASK = 6'h20;

  // Field positions and reset values
  localparam int MS_EE = 0;
  localparam int MS_PR = 1;
  localparam int HW_TSE = 0;
  localparam int AEN_SMI = 0;
  localparam int AEN_PERF = 1;
  localparam int AEN_THERM = 2;
  localparam int IS_TAKEN = 0;
  localparam int IS_MCHECK = 1;
  localparam int IS_SYSRST = 2;
  localparam logic [MS_W-1:0] MSTATE_RST = 2'h0;
  localparam logic HWCFG_RST = 1'b0;
  localparam logic [AEN_W-1:0] AEN_RST = 3'h0;
  localparam logic [IS_W-1:0] ISTAT_RST = 3'h0;
  localparam logic [IS_W-1:0] IMASK_RST = 3'h0;

  //============================================================================
  // Vector offsets
  localparam logic [PC_W-1:0] VEC_SYSRST = 32'h0000_0100;
  localparam logic [PC_W-1:0] VEC_MCHECK = 32'h0000_0200;
  localparam logic [PC_W-1:0] VEC_DSI = 32'h0000_0300;
  localparam logic [PC_W-1:0] VEC_ISI = 32'h0000_0400;
  localparam logic [PC_W-1:0] VEC_EXT = 32'h0000_0500;
  localparam logic [PC_W-1:0] VEC_ALIGN = 32'h0000_0600;
  localparam logic [PC_W-1:0] VEC_PROGRAM = 32'h0000_0700;
  localparam logic [PC_W-1:0] VEC_FP_UNAVAIL = 32'h0000_0800;
  localparam logic [PC_W-1:0] VEC_DEC = 32'h0000_0900;
  localparam logic [PC_W-1:0] VEC_SYSCALL = 32'h0000_0C00;
  localparam logic [PC_W-1:0] VEC_TRACE = 32'h0000_0D00;
  localparam logic [PC_W-1:0] VEC_PERF = 32'h0000_0F00;
  localparam logic [PC_W-1:0] VEC_ITLB_MISS = 32'h0000_1000;
  localparam logic [PC_W-1:0] VEC_DLD_MISS = 32'h0000_1100;
  localparam logic [PC_W-1:0] VEC_DST_MISS = 32'h0000_1200;
  localparam logic [PC_W-1:0] VEC_SMI = 32'h0000_1400;
  localparam logic [PC_W-1:0] VEC_THERM = 32'h0000_1700;

  // Vector offset for a cause code
  function automatic logic [PC_W-1:0] vector_offset(input logic [CODE_W-1:0] code);
    case (code)
      5'h00: vector_offset = VEC_SYSRST;
      5'h01: vector_offset = VEC_MCHECK;
      5'h02: vector_offset = VEC_ISI;
      5'h03: vector_offset = VEC_DSI;
      5'h04: vector_offset = VEC_ALIGN;
      5'h05: vector_offset = VEC_PROGRAM;
      5'h06: vector_offset = VEC_FP_UNAVAIL;
      5'h07: vector_offset = VEC_SYSCALL;
      5'h08: vector_offset = VEC_TRACE;
      5'h09: vector_offset = VEC_ITLB_MISS;
      5'h0A: vector_offset = VEC_DLD_MISS;
      5'h0B: vector_offset = VEC_DST_MISS;
      5'h0C: vector_offset = VEC_EXT;
      5'h0D: vector_offset = VEC_SMI;
      5'h0E: vector_offset = VEC_DEC;
      5'h0F: vector_offset = VEC_PERF;
      5'h10: vector_offset = VEC_THERM;
      default: vector_offset = VEC_SYSRST;
    endcase
  endfunction : vector_offset

  // True when tag a is older than tag b; window must stay below half the tag space
  function automatic logic tag_older(input logic [TAG_W-1:0] a, input logic [TAG_W-1:0] b);
    logic [TAG_W-1:0] d;
    d = a - b;
    tag_older = d[TAG_W-1];
  endfunction : tag_older

endpackage : exc_seq_pkg

//--- rtl/first_set_picker.sv
//==============================================================================
// Lowest-index request wins
module first_set_picker #(
  parameter int N = 4,
  parameter int IW = 2
) (
  // Requests
  input wire logic [N-1:0] req,
  // Result
  output logic found,
  output logic [IW-1:0] idx
);

  // Scan from the top so the lowest set bit is the last written
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = IW'(i);
      end
    end
  end

endmodule : first_set_picker

//--- rtl/oldest_fault_slot.sv
//==============================================================================
// Holds the oldest faulting instruction and all its pending conditions
module oldest_fault_slot
  import exc_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Report from the pipeline
  input wire logic rep_valid,
  input wire logic [TAG_W-1:0] rep_tag,
  input wire logic [PC_W-1:0] rep_pc,
  input wire logic [SYNC_N-1:0] rep_causes,
  // Control from the sequencer
  input wire logic clr_valid,
  input wire logic [SYNC_IW-1:0] clr_idx,
  input wire logic flush,
  // Held record
  output logic held_valid,
  output logic [TAG_W-1:0] held_tag,
  output logic [PC_W-1:0] held_pc,
  output logic [SYNC_N-1:0] held_causes
);

  logic [TAG_W-1:0] tag_reg, tag_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [SYNC_N-1:0] causes_reg, causes_next;
  logic [SYNC_N-1:0] kept;

  // Clear first, then merge the report so a same-tag or older condition is not lost; a younger tag is dropped
  always_comb begin
    tag_next = tag_reg;
    pc_next = pc_reg;
    kept = causes_reg;
    if (flush) begin
      kept = '0;
    end else if (clr_valid) begin
      kept[clr_idx] = 1'b0;
    end
    causes_next = kept;
    if (rep_valid && (rep_causes != '0)) begin
      if ((kept == '0) || tag_older(rep_tag, tag_reg)) begin
        tag_next = rep_tag;
        pc_next = rep_pc;
        causes_next = rep_causes;
      end else if (rep_tag == tag_reg) begin
        causes_next = kept | rep_causes;
      end
    end
  end

  // Record registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tag_reg <= '0;
      pc_reg <= '0;
      causes_reg <= '0;
    end else begin
      tag_reg <= tag_next;
      pc_reg <= pc_next;
      causes_reg <= causes_next;
    end
  end

  assign held_valid = (causes_reg != '0);
  assign held_tag = tag_reg;
  assign held_pc = pc_reg;
  assign held_causes = causes_reg;

endmodule : oldest_fault_slot

//--- rtl/precise_exception_sequencer.sv
//==============================================================================
// Exception recognition, ordering and handler entry
//
// Local design decisions: the register addresses and the address-and-strobe port.
module precise_exception_sequencer
  import exc_seq_pkg::*;
#(
  parameter logic [PC_W-1:0] VEC_BASE = 32'h0000_0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [RA_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Synchronous fault reports from the pipeline
  input wire logic fault_valid,
  input wire logic [TAG_W-1:0] fault_tag,
  input wire logic [PC_W-1:0] fault_pc,
  input wire logic [SYNC_N-1:0] fault_causes,
  input wire logic [31:0] fault_dsi_detail,
  // Completion status
  input wire logic [TAG_W-1:0] head_tag,
  input wire logic exec_idle,
  input wire logic [PC_W-1:0] next_pc,
  input wire logic return_req,
  // External events
  input wire logic ext_irq,
  input wire logic smi_irq,
  input wire logic perf_irq,
  input wire logic thermal_irq,
  input wire logic mcheck_in,
  input wire logic hard_reset_in,
  input wire logic soft_reset_in,
  input wire logic [31:0] decrementer_count,
  // Fetch redirection
  output logic redirect_valid,
  output logic [PC_W-1:0] redirect_addr,
  output logic flush_pipe,
  output logic supervisor,
  output logic external_irq_enable,
  // Interrupt
  output logic irq_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_SETTLE} seq_state_t;

  //============================================================================
  // State
  seq_state_t state_reg, state_next;
  logic [MS_W-1:0] machine_state_reg, machine_state_next;
  logic hw_impl_config_reg, hw_impl_config_next;
  logic [AEN_W-1:0] aen_reg, aen_next;
  logic [PC_W-1:0] save_restore_address_reg, save_restore_address_next;
  logic [MS_W-1:0] save_restore_state_reg, save_restore_state_next;
  logic [31:0] data_fault_cause_reg, data_fault_cause_next;
  logic [31:0] dfc_pend_reg, dfc_pend_next;
  logic [CODE_W-1:0] cause_reg, cause_next;
  logic [IS_W-1:0] istat_reg, istat_next;
  logic [IS_W-1:0] imask_reg, imask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [ASYNC_IW-1:0] sel_reg, sel_next;
  logic dec_msb_reg, dec_pend_reg, dec_pend_next;
  logic rst_lvl_reg, mck_lvl_reg;
  logic sysrst_pend_reg, sysrst_pend_next;
  logic mck_pend_reg, mck_pend_next;
  logic redirect_reg, redirect_next;
  logic [PC_W-1:0] raddr_reg, raddr_next;
  logic flush_reg, flush_next;

  //============================================================================
  // Fault slot and pickers
  logic slot_valid;
  logic [TAG_W-1:0] slot_tag;
  logic [PC_W-1:0] slot_pc;
  logic [SYNC_N-1:0] slot_causes;
  logic [SYNC_N-1:0] rep_causes;
  logic slot_clr, slot_flush;
  logic sync_found, async_found;
  logic [SYNC_IW-1:0] sync_idx;
  logic [ASYNC_IW-1:0] async_idx;
  logic [ASYNC_N-1:0] async_req;
  logic sync_go, ee, dec_rise, rst_rise, mck_rise;
  logic take;
  logic [CODE_W-1:0] take_code;
  logic [PC_W-1:0] take_pc;

  // Table-search misses never enter the slot while the search enable is off
  assign rep_causes = hw_impl_config_reg ? fault_causes : (fault_causes & ~TLB_MISS_MASK);

  oldest_fault_slot u_slot (
    .clk(clk),
    .rst_b(rst_b),
    .rep_valid(fault_valid),
    .rep_tag(fault_tag),
    .rep_pc(fault_pc),
    .rep_causes(rep_causes),
    .clr_valid(slot_clr),
    .clr_idx(sync_idx),
    .flush(slot_flush),
    .held_valid(slot_valid),
    .held_tag(slot_tag),
    .held_pc(slot_pc),
    .held_causes(slot_causes)
  );

  first_set_picker #(.N(SYNC_N), .IW(SYNC_IW)) u_sync_pick (
    .req(slot_causes),
    .found(sync_found),
    .idx(sync_idx)
  );

  first_set_picker #(.N(ASYNC_N), .IW(ASYNC_IW)) u_async_pick (
    .req(async_req),
    .found(async_found),
    .idx(async_idx)
  );

  //============================================================================
  // Event recognition
  assign ee = machine_state_reg[MS_EE];
  assign dec_rise = decrementer_count[31] & ~dec_msb_reg;
  assign rst_rise = (hard_reset_in | soft_reset_in) & ~rst_lvl_reg;
  assign mck_rise = mcheck_in & ~mck_lvl_reg;
  // Oldest faulting instruction at the head: every older one has completed
  assign sync_go = slot_valid & sync_found & (slot_tag == head_tag);

  // Maskable sources gated by interrupt enable, SMI, PERF and THERM also by per-source enables; the decrementer only by its pend
  always_comb begin
    async_req = '0;
    async_req[AS_EXT] = ext_irq & ee;
    async_req[AS_SMI] = smi_irq & ee & aen_reg[AEN_SMI];
    async_req[AS_DEC] = dec_pend_reg;
    async_req[AS_PERF] = perf_irq & ee & aen_reg[AEN_PERF];
    async_req[AS_THERM] = thermal_irq & ee & aen_reg[AEN_THERM];
  end

  //============================================================================
  // Sequencer: pick what to take, then apply register effects
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    take = 1'b0;
    take_code = CODE_SYSRST;
    take_pc = next_pc;
    slot_clr = 1'b0;
    slot_flush = 1'b0;
    // Reset and machine check are imprecise: no drain, no mask
    if ((state_reg != ST_SETTLE) && sysrst_pend_reg) begin
      take = 1'b1;
      take_code = CODE_SYSRST;
    end else if ((state_reg != ST_SETTLE) && mck_pend_reg) begin
      take = 1'b1;
      take_code = CODE_MCHECK;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (sync_go) begin
            take = 1'b1;
            take_code = CODE_W'(CODE_SYNC_BASE + CODE_W'(sync_idx));
            take_pc = slot_pc;
          end else if (async_found) begin
            state_next = ST_DRAIN;
            sel_next = async_idx;
          end
        end
        ST_DRAIN: begin
          if (sync_go) begin
            take = 1'b1;
            take_code = CODE_W'(CODE_SYNC_BASE + CODE_W'(sync_idx));
            take_pc = slot_pc;
          end else if (!async_req[sel_reg]) begin
            state_next = ST_IDLE;
          end else if (exec_idle) begin
            take = 1'b1;
            take_code = CODE_W'(CODE_ASYNC_BASE + CODE_W'(sel_reg));
          end
        end
        ST_SETTLE: begin
          // One cycle for the flush to reach the pipeline before re-arbitrating
          state_next = ST_IDLE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
    if (take) begin
      state_next = ST_SETTLE;
      if (take_code >= CODE_SYNC_BASE && take_code < CODE_ASYNC_BASE) begin
        slot_clr = 1'b1;
      end else begin
        slot_flush = 1'b1;
      end
    end
  end

  // Register file, pending flags and entry effects
  always_comb begin
    machine_state_next = machine_state_reg;
    hw_impl_config_next = hw_impl_config_reg;
    aen_next = aen_reg;
    save_restore_address_next = save_restore_address_reg;
    save_restore_state_next = save_restore_state_reg;
    data_fault_cause_next = data_fault_cause_reg;
    dfc_pend_next = dfc_pend_reg;
    cause_next = cause_reg;
    istat_next = istat_reg;
    imask_next = imask_reg;
    redirect_next = 1'b0;
    raddr_next = raddr_reg;
    flush_next = 1'b0;
    sysrst_pend_next = sysrst_pend_reg | rst_rise;
    mck_pend_next = mck_pend_reg | mck_rise;
    // DSI detail follows the oldest reported fault
    if (fault_valid && rep_causes[SY_DSI] &&
        (!slot_valid || !tag_older(slot_tag, fault_tag))) begin
      dfc_pend_next = fault_dsi_detail;
    end
    // Software writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_MSTATE: machine_state_next = reg_wdata[MS_W-1:0];
        OFS_HWCFG: hw_impl_config_next = reg_wdata[HW_TSE];
        OFS_AEN: aen_next = reg_wdata[AEN_W-1:0];
        OFS_SRA: save_restore_address_next = reg_wdata;
        OFS_SRS: save_restore_state_next = reg_wdata[MS_W-1:0];
        OFS_ISTAT: istat_next = istat_reg & ~reg_wdata[IS_W-1:0];
        OFS_IMASK: imask_next = reg_wdata[IS_W-1:0];
        default: begin
        end
      endcase
    end
    // Return from handler restores state and resumes
    if (return_req && !take && state_reg == ST_IDLE) begin
      machine_state_next = save_restore_state_reg;
      redirect_next = 1'b1;
      raddr_next = save_restore_address_reg;
      flush_next = 1'b1;
    end
    // Entry: save context, go supervisor, fetch at the vector
    if (take) begin
      save_restore_address_next = take_pc;
      save_restore_state_next = machine_state_reg;
      machine_state_next = MSTATE_RST;
      cause_next = take_code;
      redirect_next = 1'b1;
      raddr_next = VEC_BASE | vector_offset(take_code);
      flush_next = 1'b1;
      istat_next[IS_TAKEN] = 1'b1;
      if (take_code == CODE_SYSRST) begin
        sysrst_pend_next = rst_rise;
        istat_next[IS_SYSRST] = 1'b1;
      end
      if (take_code == CODE_MCHECK) begin
        mck_pend_next = mck_rise;
        istat_next[IS_MCHECK] = 1'b1;
      end
      if (take_code == CODE_W'(CODE_SYNC_BASE + CODE_W'(SY_DSI))) begin
        data_fault_cause_next = dfc_pend_reg;
      end
    end
    // Decrementer pend: a new rise wins over the clear by entry
    dec_pend_next = dec_pend_reg;
    if (take && take_code == CODE_W'(CODE_ASYNC_BASE + CODE_W'(AS_DEC))) begin
      dec_pend_next = 1'b0;
    end
    if (dec_rise && ee) begin
      dec_pend_next = 1'b1;
    end
    // Read data valid only in the cycle after the strobe
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_MSTATE: rdata_next = 32'(machine_state_reg);
        OFS_HWCFG: rdata_next = 32'(hw_impl_config_reg);
        OFS_AEN: rdata_next = 32'(aen_reg);
        OFS_SRA: rdata_next = save_restore_address_reg;
        OFS_SRS: rdata_next = 32'(save_restore_state_reg);
        OFS_DFC: rdata_next = data_fault_cause_reg;
        OFS_CAUSE: rdata_next = 32'(cause_reg);
        OFS_ISTAT: rdata_next = 32'(istat_reg);
        OFS_IMASK: rdata_next = 32'(imask_reg);
        default: rdata_next = '0;
      endcase
    end
  end

  //============================================================================
  // Registers; power-on leaves a system reset pending
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      sel_reg <= '0;
      machine_state_reg <= MSTATE_RST;
      hw_impl_config_reg <= HWCFG_RST;
      aen_reg <= AEN_RST;
      save_restore_address_reg <= '0;
      save_restore_state_reg <= MSTATE_RST;
      data_fault_cause_reg <= '0;
      dfc_pend_reg <= '0;
      cause_reg <= CODE_SYSRST;
      istat_reg <= ISTAT_RST;
      imask_reg <= IMASK_RST;
      rdata_reg <= '0;
      dec_msb_reg <= 1'b0;
      dec_pend_reg <= 1'b0;
      rst_lvl_reg <= 1'b0;
      mck_lvl_reg <= 1'b0;
      sysrst_pend_reg <= 1'b1;
      mck_pend_reg <= 1'b0;
      redirect_reg <= 1'b0;
      raddr_reg <= '0;
      flush_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      machine_state_reg <= machine_state_next;
      hw_impl_config_reg <= hw_impl_config_next;
      aen_reg <= aen_next;
      save_restore_address_reg <= save_restore_address_next;
      save_restore_state_reg <= save_restore_state_next;
      data_fault_cause_reg <= data_fault_cause_next;
      dfc_pend_reg <= dfc_pend_next;
      cause_reg <= cause_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      rdata_reg <= rdata_next;
      dec_msb_reg <= decrementer_count[31];
      dec_pend_reg <= dec_pend_next;
      rst_lvl_reg <= hard_reset_in | soft_reset_in;
      mck_lvl_reg <= mcheck_in;
      sysrst_pend_reg <= sysrst_pend_next;
      mck_pend_reg <= mck_pend_next;
      redirect_reg <= redirect_next;
      raddr_reg <= raddr_next;
      flush_reg <= flush_next;
    end
  end

  //============================================================================
  // Outputs
  assign reg_rdata = rdata_reg;
  assign redirect_valid = redirect_reg;
  assign redirect_addr = raddr_reg;
  assign flush_pipe = flush_reg;
  assign supervisor = ~machine_state_reg[MS_PR];
  assign external_irq_enable = machine_state_reg[MS_EE];
  assign irq_out = |(istat_reg & imask_reg);

endmodule : precise_exception_sequencer

//--- verification/pipe_model.sv
// ==========
// Completion side of the pipeline
module pipe_model
  import exc_seq_pkg::*;
(
  // Control from the bench
  input wire logic clk, rst_b, slow, retire,
  // Completion status
  output logic [TAG_W-1:0] head_tag,
  output logic exec_idle,
  output logic [PC_W-1:0] next_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] busy_reg;
  // Oldest tag moves only on retire, so completion stays in order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      head_tag <= '0;
      busy_reg <= '0;
      next_pc <= 32'h0000_2000;
    end else begin
      head_tag <= head_tag + TAG_W'(retire);
      busy_reg <= busy_reg + 2'h1;
      next_pc <= next_pc + 32'h0000_0004;
    end
  end
  // Slow mode keeps execute busy three cycles in four
  assign exec_idle = !slow || busy_reg == 2'h0;
endmodule : pipe_model

//--- verification/precise_exception_sequencer_asserts.sv
// ==========
// Port checks on the sequencer
module precise_exception_sequencer_asserts
  import exc_seq_pkg::*;
#(
  parameter logic [PC_W-1:0] VEC_BASE = 32'h0000_0000
) (
  // Watched ports
  input wire logic clk, rst_b, reg_rd, return_req, ext_irq, exec_idle,
  input wire logic mcheck_in, hard_reset_in, soft_reset_in, redirect_valid,
  input wire logic flush_pipe, supervisor, external_irq_enable,
  input wire logic [31:0] reg_rdata,
  input wire logic [PC_W-1:0] redirect_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Entry outputs; a return is not an entry
  AST_FLUSH: assert property (redirect_valid |-> flush_pipe)
    else $error("flush missing");
  AST_SUPV: assert property (redirect_valid && !$past(return_req)
    |-> supervisor && !external_irq_enable) else $error("not supervisor");
  AST_GAP: assert property (redirect_valid |=> !redirect_valid)
    else $error("entries too close");
  AST_HOLD: assert property (!redirect_valid |-> $stable(redirect_addr))
    else $error("vector moved");
  // External entry needs its request and a drained execute stage
  AST_EXT: assert property (redirect_valid && redirect_addr == VEC_BASE + VEC_EXT
    |-> $past(ext_irq)) else $error("external entry without request");
  AST_DRAIN: assert property (redirect_valid && redirect_addr == VEC_BASE + VEC_EXT
    |-> $past(exec_idle)) else $error("entry before drain");
  // Nonmaskable pins reach their vectors within a few cycles
  AST_RST: assert property ($rose(hard_reset_in || soft_reset_in) |->
    ##[1:4] redirect_valid && redirect_addr == VEC_BASE + VEC_SYSRST)
    else $error("no reset entry");
  AST_MCHK: assert property ($rose(mcheck_in) |-> ##[1:4] redirect_valid
    && redirect_addr == VEC_BASE + VEC_MCHECK) else $error("no mcheck entry");
  // Read data stands only after a read strobe
  AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("stray read data");
  // Main scenarios
  cover property (redirect_valid && redirect_addr == VEC_BASE + VEC_EXT);
  cover property (redirect_valid && $past(return_req));
  cover property ($rose(mcheck_in));
endmodule : precise_exception_sequencer_asserts

bind precise_exception_sequencer precise_exception_sequencer_asserts #(.VEC_BASE(VEC_BASE))
  u_asserts (.clk, .rst_b, .reg_rd, .return_req, .ext_irq, .exec_idle, .mcheck_in,
  .hard_reset_in, .soft_reset_in, .redirect_valid, .flush_pipe, .supervisor,
  .external_irq_enable, .reg_rdata, .redirect_addr);

//--- verification/precise_exception_sequencer_tb.sv
// ==========
// Self-checking bench for the sequencer
module precise_exception_sequencer_tb
  import exc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, fault_valid = 0, return_req = 0;
  logic ext_irq = 0, mcheck_in = 0, slow = 0, retire = 0;
  logic [1:0] rsts = 0;
  logic [2:0] aq = 0;
  logic [RA_W-1:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, fault_dsi_detail = 0, dec = 0, reg_rdata, pcv;
  logic [TAG_W-1:0] fault_tag = 0, head_tag;
  logic [SYNC_N-1:0] fault_causes = 0;
  logic [PC_W-1:0] fault_pc = 0, next_pc, redirect_addr;
  logic exec_idle, redirect_valid, flush_pipe, supervisor, external_irq_enable, irq_out;
  logic [PC_W-1:0] avec [3] = '{VEC_SMI, VEC_PERF, VEC_THERM};
  int n_mismatch = 0, tests_run = 0, seed = 69875;
  // Design and pipeline partner
  precise_exception_sequencer u_precise_exception_sequencer (.clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fault_valid, .fault_tag, .fault_pc,
    .fault_causes, .fault_dsi_detail, .head_tag, .exec_idle, .next_pc, .return_req,
    .ext_irq, .smi_irq(aq[0]), .perf_irq(aq[1]), .thermal_irq(aq[2]), .mcheck_in,
    .hard_reset_in(rsts[1]), .soft_reset_in(rsts[0]), .decrementer_count(dec),
    .redirect_valid, .redirect_addr, .flush_pipe, .supervisor, .external_irq_enable, .irq_out);
  pipe_model u_pipe_model (.clk, .rst_b, .slow, .retire, .head_tag, .exec_idle, .next_pc);
  // ==========
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [RA_W-1:0] a, input logic [31:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [RA_W-1:0] a, input logic [31:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 0;
    #1 chk("rdata", reg_rdata, e);
  endtask : rd
  // Bounded wait, so a lost entry shows as a mismatch, not a hang
  task automatic redir(input logic [PC_W-1:0] e);
    // Skip a pulse left by the previous entry
    @(negedge clk);
    for (int i = 0; i < 30 && redirect_valid !== 1'b1; i++) @(negedge clk);
    chk("redirect", {redirect_valid, redirect_addr[30:0]}, {1'b1, e[30:0]});
  endtask : redir
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      chk("quiet", redirect_valid, 0);
    end
  endtask : quiet
  task automatic flt(input logic [TAG_W-1:0] t, input logic [SYNC_N-1:0] c);
    pcv = $random(seed);
    @(posedge clk) {fault_valid, fault_tag, fault_causes, fault_pc} <= {1'b1, t, c, pcv};
    fault_dsi_detail <= ~pcv;
    @(posedge clk) fault_valid <= 0;
  endtask : flt
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // ==========
  // Clock and watchdog; the run needs well under a thousand cycles
  initial forever #12.5 clk = ~clk;
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    redir(VEC_SYSRST);
    rd(OFS_CAUSE, CODE_SYSRST);
    flt(head_tag + 6'h01, 10'h008);
    quiet(5);
    flt(head_tag, 10'h001);
    redir(VEC_ISI);
    rd(OFS_SRA, pcv);
    flt(head_tag + 6'h01, 10'h028);
    quiet(3);
    @(posedge clk) retire <= 1;
    @(posedge clk) retire <= 0;
    redir(VEC_PROGRAM);
    redir(VEC_SYSCALL);
    flt(head_tag, 10'h002);
    redir(VEC_DSI);
    rd(OFS_DFC, ~pcv);
    flt(head_tag, 10'h080);
    quiet(4);
    wr(OFS_HWCFG, 32'h0000_0001);
    for (int j = 7; j < 10; j++) begin
      flt(head_tag, 10'h001 << j);
      redir(VEC_ITLB_MISS + 32'(j - 7) * 32'h0000_0100);
    end
    // Maskable events wait for enables and a drained execute stage
    @(posedge clk) {slow, ext_irq} <= 2'b11;
    quiet(4);
    wr(OFS_MSTATE, 32'h0000_0001);
    redir(VEC_EXT);
    chk("state", {supervisor, external_irq_enable}, 2'b10);
    @(posedge clk) ext_irq <= 0;
    foreach (avec[i]) begin
      wr(OFS_MSTATE, 32'h0000_0001);
      @(posedge clk) aq <= 3'h1 << i;
      quiet(3);
      wr(OFS_AEN, 32'h0000_0001 << i);
      redir(avec[i]);
      @(posedge clk) aq <= 0;
    end
    @(posedge clk) dec <= $random(seed) & 32'h7FFF_FFFF;
    wr(OFS_MSTATE, 32'h0000_0001);
    @(posedge clk) dec <= dec | 32'h8000_0000;
    redir(VEC_DEC);
    // Nonmaskable entries with interrupts off, then status and mask
    @(posedge clk) mcheck_in <= 1;
    redir(VEC_MCHECK);
    wr(OFS_IMASK, 32'h0000_0002);
    chk("irq", irq_out, 1);
    wr(OFS_ISTAT, 32'h0000_0002);
    chk("irq", irq_out, 0);
    pcv = $random(seed);
    wr(OFS_SRA, pcv);
    @(posedge clk) {return_req, mcheck_in} <= 2'b10;
    @(posedge clk) return_req <= 0;
    redir(pcv);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) rsts <= i ? 2'b10 : 2'b01;
      redir(VEC_SYSRST);
      @(posedge clk) rsts <= 0;
    end
    rd(6'h3C, 32'h0000_0000);
    end_sim;
  end
endmodule : precise_exception_sequencer_tb
